/* design/qcm_pkg.sv */
// qcm_pkg: constants shared by the four-line command mode switch
package qcm_pkg;
    // ----------------------------------------
    // opcodes
    // ----------------------------------------
    localparam logic [7:0] OP_MODE_ENTER = 8'h38;   // enter four-line mode
    localparam logic [7:0] OP_MODE_EXIT  = 8'hff;   // leave four-line mode
    localparam logic [7:0] OP_SFDP_READ  = 8'h5a;   // discoverable parameter read
    // ----------------------------------------
    // delivery state values
    // ----------------------------------------
    localparam logic [7:0] ERASED_BYTE   = 8'hff;   // erased array byte
    localparam logic [7:0] STATUS_RESET  = 8'h00;   // status register at delivery
    // ----------------------------------------
    // widths and counts
    // ----------------------------------------
    localparam int OP_BITS      = 8;                // opcode length
    localparam int NIB_BITS     = 4;                // bits per clock in four-line mode
    localparam int ADDR_BITS    = 24;               // sfdp address bytes x8
    localparam int SFDP_DUMMY   = 8;                // dummy clocks after address
    localparam int CLK_MHZ      = 125;              // system clock rate
    localparam int PWRUP_US     = 700;              // power_up_delay, least time
    localparam int PWRUP_CYCLES = PWRUP_US * CLK_MHZ; // exact product, no rounding
    // ----------------------------------------
    // command decoder states
    // ----------------------------------------
    typedef enum logic [2:0] {
        QCM_OPCODE, QCM_ADDR, QCM_DUMMY, QCM_DATA, QCM_IGNORE
    } qcm_state_e;
endpackage

/* design/qcm_pwrup_timer.sv */
// qcm_pwrup_timer: counts the power_up_delay after reset release
`timescale 1ns/100ps
module qcm_pwrup_timer #(
    parameter int CYCLES = qcm_pkg::PWRUP_CYCLES
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // status
    output logic      ready
);
    import qcm_pkg::*;

    typedef struct packed {
        logic [31:0] cnt;   // cycles elapsed
        logic        done;  // delay over
    } qcm_tmr_s;

    qcm_tmr_s st_reg;   // state
    qcm_tmr_s st_next;  // next state

    // ----------------------------------------
    // counter
    // ----------------------------------------
    always_comb
    begin
        st_next = st_reg;
        if (!st_reg.done)
        begin
            st_next.cnt = st_reg.cnt + 32'h1;
            // commands are only honoured once this is set
            if (st_reg.cnt == 32'(CYCLES - 1))
                st_next.done = 1'b1;
        end
    end

    // state register
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign ready = st_reg.done;

    // ready never comes early: it first shows with the count at the full delay
    ready_not_early_a : assert property (@(posedge clk) disable iff (!resetn)
        ready |-> st_reg.cnt == 32'(CYCLES) || $past(ready))
        else $error("ready rose before delay ended");
endmodule

/* design/qcm_mode_switch.sv */
// qcm_mode_switch: command decoder for spi / four-line command mode switching
`timescale 1ns/100ps
module qcm_mode_switch #(
    parameter int PWRUP = qcm_pkg::PWRUP_CYCLES,   // power_up_delay in cycles
    parameter int SFDP_AW = 8                        // sfdp table address width
) (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 resetn,
    // serial link, io_in sampled on clk when sclk_rise is high, cs_n on every clk
    input  wire logic                 cs_n,
    input  wire logic                 sclk_rise,
    input  wire logic [3:0]           io_in,
    output logic [3:0]                io_out,
    output logic [3:0]                io_oe,
    // device state, kept outside this block
    input  wire logic                 quad_enable_flag,
    input  wire logic                 wel_in,
    input  wire logic                 suspend_in,
    input  wire logic [2:0]           wrap_in,
    // sfdp table lookup
    output logic [SFDP_AW-1:0]        sfdp_addr,
    input  wire logic [7:0]           sfdp_data,
    // status
    output logic                      four_line_command_mode,
    output logic                      dev_ready,
    output logic [7:0]                status_out,
    output logic [7:0]                array_read_byte,
    output logic                      opcode_valid,
    output logic [7:0]                opcode_out,
    output logic                      wel_out,
    output logic                      suspend_out,
    output logic [2:0]                wrap_out
);
    import qcm_pkg::*;

    typedef struct packed {
        qcm_state_e  state;     // decoder phase
        logic        qmode;     // four-line command mode
        logic [7:0]  shreg;     // incoming shift register
        logic [5:0]  bitcnt;    // bits taken in current phase
        logic [23:0] addr;      // sfdp address
        logic [7:0]  txbyte;    // byte being sent
        logic [3:0]  dout;      // registered data out
        logic        oe;        // driving io
        logic        opv;       // opcode pulse
        logic [7:0]  op;        // last opcode
    } qcm_s;

    qcm_s st_reg;   // registered state
    qcm_s st_next;  // next state

    logic        ready;     // power_up_delay elapsed
    logic [7:0]  shifted;   // shift register after this edge
    logic [5:0]  step;      // bits per sclk in current mode

    // ----------------------------------------
    // power-up timer
    // ----------------------------------------
    qcm_pwrup_timer #(
        .CYCLES (PWRUP)
    ) u_tmr (
        .clk    (clk),
        .resetn (resetn),
        .ready  (ready)
    );

    // ----------------------------------------
    // decoder
    // ----------------------------------------
    always_comb
    begin
        st_next     = st_reg;
        st_next.opv = 1'b0;
        step    = st_reg.qmode ? 6'(NIB_BITS) : 6'h1;
        // four-line mode takes a nibble msn first, spi takes one bit
        shifted = st_reg.qmode ? {st_reg.shreg[3:0], io_in}
                               : {st_reg.shreg[6:0], io_in[0]};
        if (cs_n)
        begin
            // chip select high ends any transaction
            st_next.state  = QCM_OPCODE;
            st_next.bitcnt = '0;
            st_next.oe     = 1'b0;
        end
        else if (sclk_rise)
        begin
            st_next.shreg  = shifted;
            st_next.bitcnt = st_reg.bitcnt + step;
            unique case (st_reg.state)
                QCM_OPCODE:
                if (st_reg.bitcnt + step == 6'(OP_BITS))
                begin
                    st_next.bitcnt = '0;
                    st_next.op     = shifted;
                    // commands before power_up_delay are dropped
                    st_next.opv    = ready;
                    st_next.state  = QCM_IGNORE;
                    if (!ready)
                        st_next.state = QCM_IGNORE;
                    // entry only with quad flag set, else stays spi
                    else if (shifted == OP_MODE_ENTER && !st_reg.qmode)
                        st_next.qmode = quad_enable_flag;
                    // exit only from four-line mode
                    else if (shifted == OP_MODE_EXIT && st_reg.qmode)
                        st_next.qmode = 1'b0;
                    else if (shifted == OP_SFDP_READ)
                        st_next.state = QCM_ADDR;
                end
                QCM_ADDR:
                begin
                    st_next.addr = st_reg.qmode ? {st_reg.addr[19:0], io_in}
                                                : {st_reg.addr[22:0], io_in[0]};
                    if (st_reg.bitcnt + step == 6'(ADDR_BITS))
                    begin
                        st_next.bitcnt = '0;
                        st_next.state  = QCM_DUMMY;
                    end
                end
                QCM_DUMMY:
                if (st_reg.bitcnt + 6'h1 == 6'(SFDP_DUMMY))
                begin
                    // load the first table byte
                    st_next.bitcnt = '0;
                    st_next.state  = QCM_DATA;
                    st_next.txbyte = sfdp_data;
                    st_next.oe     = 1'b1;
                    st_next.dout   = st_reg.qmode ? sfdp_data[7:4]
                                                  : {2'b00, sfdp_data[7], 1'b0};
                    st_next.bitcnt = step;
                    st_next.addr   = st_reg.addr + 24'h1;
                end
                else
                    st_next.bitcnt = st_reg.bitcnt + 6'h1;
                QCM_DATA:
                begin
                    // send table bytes msb first, address steps per byte
                    if (st_reg.bitcnt == 6'(OP_BITS))
                    begin
                        st_next.txbyte = sfdp_data;
                        st_next.addr   = st_reg.addr + 24'h1;
                        st_next.bitcnt = step;
                        st_next.dout   = st_reg.qmode ? sfdp_data[7:4]
                                                      : {2'b00, sfdp_data[7], 1'b0};
                    end
                    else
                    begin
                        st_next.txbyte = st_reg.qmode ? {st_reg.txbyte[3:0], 4'h0}
                                                      : {st_reg.txbyte[6:0], 1'b0};
                        st_next.dout   = st_reg.qmode ? st_reg.txbyte[3:0]
                                                      : {2'b00, st_reg.txbyte[6], 1'b0};
                    end
                end
                QCM_IGNORE:
                    st_next.bitcnt = st_reg.bitcnt;   // wait for cs high
                default:
                    st_next.state = QCM_IGNORE;
            endcase
        end
    end

    // state register
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_reg        <= '0;
            st_reg.state  <= QCM_OPCODE;
        end
        else
            st_reg <= st_next;
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign four_line_command_mode = st_reg.qmode;
    assign dev_ready              = ready;
    assign io_out                 = st_reg.dout;
    // spi sends on io1 only, four-line mode uses all lanes
    assign io_oe                  = st_reg.oe ? (st_reg.qmode ? 4'hf : 4'h2) : 4'h0;
    assign sfdp_addr              = st_reg.addr[SFDP_AW-1:0];
    assign opcode_valid           = st_reg.opv;
    assign opcode_out             = st_reg.op;
    // mode change never touches these
    assign wel_out                = wel_in;
    assign suspend_out            = suspend_in;
    assign wrap_out               = wrap_in;
    // delivery values
    assign status_out             = STATUS_RESET;
    assign array_read_byte        = ERASED_BYTE;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence enter_op_s;
        opcode_valid && opcode_out == OP_MODE_ENTER;
    endsequence

    mode_enter_a : assert property (@(posedge clk) disable iff (!resetn)
        enter_op_s and $past(quad_enable_flag) |-> four_line_command_mode)
        else $error("enter opcode with quad flag did not enter mode");

    enter_gated_a : assert property (@(posedge clk) disable iff (!resetn)
        $rose(four_line_command_mode) |-> enter_op_s and $past(quad_enable_flag))
        else $error("mode entered without quad flag");

    mode_exit_a : assert property (@(posedge clk) disable iff (!resetn)
        opcode_valid && opcode_out == OP_MODE_EXIT |-> !four_line_command_mode)
        else $error("exit opcode left mode set");

    keep_state_a : assert property (@(posedge clk) disable iff (!resetn)
        $changed(four_line_command_mode) |->
            wel_out == wel_in && suspend_out == suspend_in && wrap_out == wrap_in)
        else $error("mode change altered kept state");

    no_early_cmd_a : assert property (@(posedge clk) disable iff (!resetn)
        opcode_valid |-> dev_ready)
        else $error("command taken before power-up delay");

    // enables drop one cycle after chip select rises, so look at the previous sample
    sfdp_drive_a : assert property (@(posedge clk) disable iff (!resetn)
        io_oe != 4'h0 |-> $past(!cs_n) && st_reg.state == QCM_DATA)
        else $error("io driven outside sfdp data phase");

    deliver_a : assert property (@(posedge clk) disable iff (!resetn)
        status_out == 8'h00 && array_read_byte == 8'hff)
        else $error("delivery values wrong");

    quad_opcode_a : assert property (@(posedge clk) disable iff (!resetn)
        opcode_valid && $past(four_line_command_mode) |->
            opcode_out[3:0] == $past(io_in))
        else $error("four-line opcode low nibble not last");
endmodule

/* verification/qcm_host_model.sv */
// qcm_host_model: host controller model that drives the serial link of the switch
`timescale 1ns/100ps
module qcm_host_model (
    // clock
    input  wire logic       clk,
    // serial link
    output logic            cs_n,
    output logic            sclk_rise,
    output logic [3:0]      io_in,
    input  wire logic [3:0] io_out,
    input  wire logic [3:0] io_oe
);
    // idle link: deselected, serial clock standing still
    initial
    begin
        cs_n      = 1'b1;
        sclk_rise = 1'b0;
        io_in     = 4'h0;
    end

    // one serial clock rise; lines flip after it so stale data never looks valid
    task automatic pulse(input logic [3:0] v);
        @(posedge clk) #1;
        sclk_rise = 1'b1;
        io_in     = v;
        @(posedge clk) #1;
        sclk_rise = 1'b0;
        io_in     = ~v;
    endtask

    // one byte msb first; four-line mode sends the upper nibble first
    task automatic send_byte(input logic [7:0] b, input logic quad);
        if (quad)
        begin
            pulse(b[7:4]);
            pulse(b[3:0]);
        end
        else
            for (int i = 7; i >= 0; i--)
                pulse({3'h0, b[i]});
    endtask

    // frame edges: at least one idle clk with cs_n high between commands
    task automatic open_frame;
        @(posedge clk) #1;
        cs_n = 1'b0;
    endtask
    task automatic close_frame;
        @(posedge clk) #1;
        cs_n = 1'b1;
        @(posedge clk);
    endtask

    // single opcode in its own frame
    task automatic cmd(input logic [7:0] op, input logic quad);
        open_frame();
        send_byte(op, quad);
        close_frame();
    endtask

    // parameter read in spi: opcode, 24 address bits, 8 dummy clocks, two bytes
    task automatic sfdp(input logic [7:0] a, output logic [15:0] d, output logic [3:0] oe);
        open_frame();
        send_byte(8'h5a, 1'b0);
        send_byte(8'h00, 1'b0);
        send_byte(8'h00, 1'b0);
        send_byte(a, 1'b0);
        repeat (8) pulse(4'h0);
        oe = io_oe;
        for (int k = 0; k < 16; k++)
        begin
            if (k > 0)
                pulse(4'h0);
            d[15-k] = io_out[1];
        end
        close_frame();
    endtask
endmodule

/* verification/qcm_mode_switch_tb.sv */
// qcm_mode_switch_tb: self-checking bench for the four-line command mode switch
`timescale 1ns/100ps
module qcm_mode_switch_tb;
    import qcm_pkg::*;
    localparam int PW = 40;            // shortened power_up_delay
    logic        clk, resetn, cs_n, sclk_rise, qflag, wel, susp;
    logic        mode, ready, opv, wel_o, susp_o;
    logic [3:0]  io_in, io_out, io_oe, oe;
    logic [2:0]  wrap, wrap_o;
    logic [7:0]  sfdp_addr, sfdp_data, status, arr, op, last_op;
    logic [15:0] rd;
    int          err_count, n_checks, n_ops;

    // table answer derived from the address so every byte is distinct
    assign sfdp_data = sfdp_addr ^ 8'ha5;

    qcm_mode_switch #(.PWRUP(PW)) u_dut (
        .clk(clk), .resetn(resetn), .cs_n(cs_n), .sclk_rise(sclk_rise),
        .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .quad_enable_flag(qflag),
        .wel_in(wel), .suspend_in(susp), .wrap_in(wrap), .sfdp_addr(sfdp_addr),
        .sfdp_data(sfdp_data), .four_line_command_mode(mode), .dev_ready(ready),
        .status_out(status), .array_read_byte(arr), .opcode_valid(opv),
        .opcode_out(op), .wel_out(wel_o), .suspend_out(susp_o), .wrap_out(wrap_o));

    qcm_host_model u_host (
        .clk(clk), .cs_n(cs_n), .sclk_rise(sclk_rise), .io_in(io_in),
        .io_out(io_out), .io_oe(io_oe));

    // ----------------------------------------
    // clock, opcode monitor, compare and close
    // ----------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // taken opcodes counted on the pulse, since it stands one cycle only
    always @(posedge clk)
        if (opv === 1'b1)
        begin
            n_ops++;
            last_op = op;
        end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // hang guard, far above the few hundred cycles the tests need
    initial
    begin
        #20000;
        err_count++;
        report_and_stop();
    end

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        resetn = 1'b0;
        qflag  = 1'b1;
        wel    = 1'b1;
        susp   = 1'b0;
        wrap   = 3'h5;
        n_ops  = 0;
        repeat (2) @(posedge clk);
        #1 resetn = 1'b1;
        // delivery state and power-up wait
        check(status, STATUS_RESET);
        check(arr, ERASED_BYTE);
        check(ready, 1'b0);
        u_host.cmd(OP_MODE_ENTER, 1'b0);           // too early, must be dropped
        check(mode, 1'b0);
        check(n_ops[7:0], 8'h00);
        repeat (PW) @(posedge clk);                // host honours the wait
        check(ready, 1'b1);
        $display("test power_up done");
        // entry refused while the quad flag is clear
        #1 qflag = 1'b0;
        u_host.cmd(OP_MODE_ENTER, 1'b0);
        check(last_op, OP_MODE_ENTER);
        check(mode, 1'b0);
        u_host.cmd(OP_MODE_EXIT, 1'b0);            // exit in spi changes nothing
        check(mode, 1'b0);
        $display("test refused_entry done");
        // entry with flag set, side state kept
        #1 qflag = 1'b1;                           // host sets the flag first
        susp  = 1'b1;
        u_host.cmd(OP_MODE_ENTER, 1'b0);
        check(mode, 1'b1);
        check(wel_o, 1'b1);
        check(susp_o, 1'b1);
        check(wrap_o, 3'h5);
        u_host.cmd(OP_MODE_ENTER, 1'b1);           // enter again while in mode
        check(last_op, OP_MODE_ENTER);
        check(mode, 1'b1);
        $display("test entry done");
        // four-line opcodes, then exit
        u_host.cmd(8'h5a, 1'b1);                   // a nibble-swapped value tells order
        check(last_op, 8'h5a);
        check(mode, 1'b1);
        u_host.cmd(OP_MODE_EXIT, 1'b1);
        check(last_op, OP_MODE_EXIT);
        check(mode, 1'b0);
        check(wel_o, 1'b1);
        check(susp_o, 1'b1);
        check(wrap_o, 3'h5);
        $display("test exit done");
        // parameter table read across a byte boundary
        u_host.sfdp(8'h10, rd, oe);
        check(rd[15:8], 8'h10 ^ 8'ha5);
        check(rd[7:0], 8'h11 ^ 8'ha5);
        check({4'h0, oe}, 8'h02);
        check(sfdp_addr, 8'h12);
        $display("test parameter_read done");
        report_and_stop();
    end
endmodule
